//--- bcsq_map.svh
// Constants for the sequencer control operation group
`ifndef BCSQ_MAP_SVH
`define BCSQ_MAP_SVH
`define BCSQ_OP_RETURN 16'h0004
`define BCSQ_OP_IRQ 16'h0006
`define BCSQ_OP_STOP 16'h0007
`define BCSQ_OP_DELAY 16'h0008
`define BCSQ_OP_WAIT_FRAME 16'h0009
`define BCSQ_OP_CMP_FRAME 16'h000A
`define BCSQ_OP_CMP_MSG 16'h000B
`define BCSQ_STACK_DEPTH 3'h4
`define BCSQ_IRQ_LSB 2
`define BCSQ_IRQ_MSB 5
`define BCSQ_FLAG_RESET 1'h0
`define BCSQ_TICK_NS 1000
`define BCSQ_CLK_NS 10
`define BCSQ_CYC_PER_US (`BCSQ_TICK_NS / `BCSQ_CLK_NS)
`endif

//--- bcsq_pkg.sv
// Types for the sequencer control operation group
package bcsq_pkg;
  typedef logic [15:0] bcsq_word_type;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_WAITF} bcsq_state_type;
  typedef struct packed {
    bcsq_state_type state;
    logic [3:0][15:0] stack;
    logic [2:0] depth;
    logic ready;
    logic done;
    logic ret_valid;
    logic [15:0] ret_addr;
    logic [3:0] irq;
    logic stopped;
    logic below;
    logic at_or_above;
    logic same;
    logic differ;
    logic tmr_load;
  } bcsq_ops_type;
  typedef struct packed {
    logic [15:0] remain;
    logic [6:0] div;
    logic busy;
    logic done;
  } bcsq_tmr_type;
endpackage

//--- bcsq_us_timer.sv
// Microsecond countdown timer used by the timed wait operation
`timescale 1ns/10ps
`include "bcsq_map.svh"
module bcsq_us_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Load and expiry
  input wire logic load,
  input wire bcsq_pkg::bcsq_word_type load_value,
  output logic done
);
  import bcsq_pkg::*;
  localparam logic [6:0] TICK_LAST = 7'(`BCSQ_CYC_PER_US - 1);
  bcsq_tmr_type r_reg;
  bcsq_tmr_type r_next;

  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (load)
    begin
      r_next.remain = load_value;
      r_next.div = 7'h00;
      r_next.busy = (load_value != 16'h0000);
      r_next.done = (load_value == 16'h0000);
    end
    else if (r_reg.busy)
    begin
      if (r_reg.div == TICK_LAST)
      begin
        r_next.div = 7'h00;
        if (r_reg.remain == 16'h0001)
        begin
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
        end
        r_next.remain = r_reg.remain - 16'h0001;
      end
      else
      begin
        r_next.div = r_reg.div + 7'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign done = r_reg.done;
endmodule

//--- bcsq_ctrl_ops.sv
// Sequencer return, interrupt, stop, wait and timer compare operations
`timescale 1ns/10ps
`include "bcsq_map.svh"
module bcsq_ctrl_ops (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction issue
  input wire logic instr_valid,
  input wire bcsq_pkg::bcsq_word_type opcode,
  input wire bcsq_pkg::bcsq_word_type param,
  input wire logic cond_true,
  output logic instr_ready,
  output logic instr_done,
  // Return target
  output logic return_valid,
  output bcsq_pkg::bcsq_word_type return_addr,
  // Call push from the call operation
  input wire logic push_valid,
  input wire bcsq_pkg::bcsq_word_type push_addr,
  output logic [2:0] stack_depth,
  // Host control
  input wire logic start_cmd,
  output logic stopped,
  // Interrupt status bits 5-2
  output logic [3:0] irq_set,
  // Timer counts
  input wire bcsq_pkg::bcsq_word_type frame_time,
  input wire bcsq_pkg::bcsq_word_type msg_time,
  // Shared flags
  input wire logic host_flag_wr,
  input wire logic host_user_flag_a,
  input wire logic host_user_flag_b,
  output logic below_flag,
  output logic at_or_above_flag,
  output logic same_flag,
  output logic differ_flag
);
  import bcsq_pkg::*;
  bcsq_ops_type r_reg;
  bcsq_ops_type r_next;
  logic take;
  logic tmr_done;
  logic is_cond_op;
  bcsq_word_type top_addr;

  // Returns below, at_or_above, same, differ
  function automatic logic [3:0] cmp_flags(input bcsq_word_type p, input bcsq_word_type c);
    cmp_flags = {p < c, p >= c, p == c, p != c};
  endfunction

  assign take = instr_valid && r_reg.ready;
  assign is_cond_op = (opcode == `BCSQ_OP_RETURN) || (opcode == `BCSQ_OP_IRQ) ||
    (opcode == `BCSQ_OP_STOP) || (opcode == `BCSQ_OP_DELAY) || (opcode == `BCSQ_OP_WAIT_FRAME);
  assign top_addr = r_reg.stack[2'(r_reg.depth - 3'h1)];

  bcsq_us_timer u_timer (
    .clk(clk),
    .srst(srst),
    .load(r_reg.tmr_load),
    .load_value(param),
    .done(tmr_done)
  );

  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.ret_valid = 1'b0;
    r_next.irq = 4'h0;
    r_next.tmr_load = 1'b0;
    if (host_flag_wr)
    begin
      r_next.below = host_user_flag_a;
      r_next.at_or_above = !host_user_flag_a;
      r_next.differ = host_user_flag_b;
      r_next.same = !host_user_flag_b;
    end
    if (push_valid && (r_reg.depth < `BCSQ_STACK_DEPTH) &&
        !(take && (opcode == `BCSQ_OP_RETURN)))
    begin
      r_next.stack[2'(r_reg.depth)] = push_addr;
      r_next.depth = r_reg.depth + 3'h1;
    end
    if (start_cmd)
      r_next.stopped = 1'b0;
    case (r_reg.state)
      ST_IDLE:
      begin
        if (take)
        begin
          r_next.done = 1'b1;
          case (opcode)
            `BCSQ_OP_RETURN:
            begin
              if (cond_true && (r_reg.depth != 3'h0))
              begin
                r_next.depth = r_reg.depth - 3'h1;
                r_next.ret_addr = top_addr;
                r_next.ret_valid = 1'b1;
              end
            end
            `BCSQ_OP_IRQ:
            begin
              if (cond_true)
                r_next.irq = param[3:0];
            end
            `BCSQ_OP_STOP:
            begin
              if (cond_true)
                r_next.stopped = 1'b1;
            end
            `BCSQ_OP_DELAY:
            begin
              if (cond_true)
              begin
                r_next.done = 1'b0;
                r_next.tmr_load = 1'b1;
                r_next.state = ST_DELAY;
              end
            end
            `BCSQ_OP_WAIT_FRAME:
            begin
              if (cond_true)
              begin
                r_next.done = 1'b0;
                r_next.state = ST_WAITF;
              end
            end
            `BCSQ_OP_CMP_FRAME:
            begin
              {r_next.below, r_next.at_or_above, r_next.same, r_next.differ} =
                cmp_flags(param, frame_time);
            end
            `BCSQ_OP_CMP_MSG:
            begin
              {r_next.below, r_next.at_or_above, r_next.same, r_next.differ} =
                cmp_flags(param, msg_time);
            end
            default:
            begin
              r_next.done = 1'b1;
            end
          endcase
        end
      end
      ST_DELAY:
      begin
        if (tmr_done)
        begin
          r_next.done = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      ST_WAITF:
      begin
        if (frame_time == 16'h0000)
        begin
          r_next.done = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      default:
      begin
        r_next.state = ST_IDLE;
      end
    endcase
    r_next.ready = (r_next.state == ST_IDLE) && !r_next.stopped;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r_reg <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.below <= `BCSQ_FLAG_RESET;
      r_reg.at_or_above <= !`BCSQ_FLAG_RESET;
      r_reg.same <= !`BCSQ_FLAG_RESET;
      r_reg.differ <= `BCSQ_FLAG_RESET;
      r_reg.ready <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign instr_ready = r_reg.ready;
  assign instr_done = r_reg.done;
  assign return_valid = r_reg.ret_valid;
  assign return_addr = r_reg.ret_addr;
  assign stack_depth = r_reg.depth;
  assign stopped = r_reg.stopped;
  assign irq_set = r_reg.irq;
  assign below_flag = r_reg.below;
  assign at_or_above_flag = r_reg.at_or_above;
  assign same_flag = r_reg.same;
  assign differ_flag = r_reg.differ;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_take_cond(logic [15:0] op);
    take && cond_true && (opcode == op);
  endsequence

  a_return_pop: assert property (s_take_cond(`BCSQ_OP_RETURN) and (r_reg.depth != 3'h0) |=> return_valid && (return_addr == $past(top_addr))) else $error("return pop wrong");
  a_false_advance: assert property (take && is_cond_op && !cond_true |=> instr_done && !return_valid && (irq_set == 4'h0) && (r_reg.state == ST_IDLE)) else $error("false op not advanced");
  a_irq_pattern: assert property (s_take_cond(`BCSQ_OP_IRQ) |=> irq_set == $past(param[3:0])) else $error("irq pattern wrong");
  a_irq_source: assert property ((irq_set != 4'h0) |-> $past(take && cond_true && (opcode == `BCSQ_OP_IRQ))) else $error("irq without request");
  a_stop_holds: assert property (s_take_cond(`BCSQ_OP_STOP) ##1 !start_cmd |=> stopped && !instr_ready) else $error("stop not held");
  a_delay_waits: assert property (s_take_cond(`BCSQ_OP_DELAY) and (param != 16'h0000) |=> !instr_done [*8]) else $error("delay ended early");
  a_frame_wait: assert property ((r_reg.state == ST_WAITF) && (frame_time != 16'h0000) |=> !instr_done) else $error("frame wait released early");
  a_frame_cmp: assert property (take && (opcode == `BCSQ_OP_CMP_FRAME) |=> (below_flag == ($past(param) < $past(frame_time))) && (same_flag == ($past(param) == $past(frame_time))) && (at_or_above_flag != below_flag) && (differ_flag != same_flag)) else $error("frame compare flags wrong");
  a_msg_cmp: assert property (take && (opcode == `BCSQ_OP_CMP_MSG) |=> (below_flag == ($past(param) < $past(msg_time))) && (same_flag == ($past(param) == $past(msg_time)))) else $error("message compare flags wrong");
  a_stack_bound: assert property (stack_depth <= `BCSQ_STACK_DEPTH) else $error("stack too deep");
  a_flags_hold: assert property ($changed(below_flag) || $changed(same_flag) |-> $past(host_flag_wr) || $past(take && ((opcode == `BCSQ_OP_CMP_FRAME) || (opcode == `BCSQ_OP_CMP_MSG)))) else $error("flag changed unexpectedly");
endmodule

//--- bcsq_host_model.sv
// Host model: frame counter source and restart after a stop
`timescale 1ns/10ps
module bcsq_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Frame counter
  input wire logic frame_run,
  input wire bcsq_pkg::bcsq_word_type frame_start,
  output bcsq_pkg::bcsq_word_type frame_time,
  // Stop and restart
  input wire logic stopped,
  output logic start_cmd
);
  import bcsq_pkg::*;
  logic [2:0] wait_reg;
  always_ff @(posedge clk)
  begin
    if (srst || !frame_run)
      frame_time <= frame_start;
    else if (frame_time != 16'h0000)
      frame_time <= frame_time - 16'h0001;
    wait_reg <= (srst || !stopped) ? 3'h0 : wait_reg + 3'h1;
    start_cmd <= !srst && stopped && wait_reg == 3'h3;
  end
endmodule

//--- bc_sequencer_control_ops_tb.sv
// Self-checking testbench for the sequencer control operations
`timescale 1ns/10ps
module bc_sequencer_control_ops_tb;
  import bcsq_pkg::*;
  logic clk = 0, srst = 1, instr_valid = 0, cond_true = 0, push_valid = 0;
  logic host_flag_wr = 0, host_user_flag_a = 0, host_user_flag_b = 0, frame_run = 0;
  bcsq_word_type opcode = 0, param = 0, push_addr = 0, msg_time = 16'h0100;
  bcsq_word_type frame_start = 16'h0040, frame_time, return_addr;
  logic instr_ready, instr_done, return_valid, stopped, start_cmd;
  logic below_flag, at_or_above_flag, same_flag, differ_flag;
  logic [2:0] stack_depth;
  logic [3:0] irq_set, flags;
  int n_errors = 0, num_checks = 0, cyc;
  assign flags = {below_flag, at_or_above_flag, same_flag, differ_flag};
  bcsq_ctrl_ops u_bcsq_ctrl_ops (.clk, .srst, .instr_valid, .opcode, .param, .cond_true,
    .instr_ready, .instr_done, .return_valid, .return_addr, .push_valid, .push_addr,
    .stack_depth, .start_cmd, .stopped, .irq_set, .frame_time, .msg_time, .host_flag_wr,
    .host_user_flag_a, .host_user_flag_b, .below_flag, .at_or_above_flag, .same_flag,
    .differ_flag);
  bcsq_host_model u_bcsq_host_model (.clk, .srst, .frame_run, .frame_start, .frame_time,
    .stopped, .start_cmd);
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Offer one instruction, hold until taken, count cycles to done
  task automatic issue(input bcsq_word_type op, input bcsq_word_type p, input logic c);
    @(posedge clk);
    #1;
    instr_valid = 1;
    opcode = op;
    param = p;
    cond_true = c;
    while (instr_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    instr_valid = 0;
    cyc = 1;
    while (instr_done !== 1'b1 && cyc < 1000)
    begin
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask
  task automatic t_compare;
    bcsq_word_type base, p, want;
    for (int i = 0; i < 6; i++)
    begin
      base = (i < 3) ? 16'h0040 : msg_time;
      p = base + 16'(i % 3) - 16'h0001;
      issue((i < 3) ? 16'h000A : 16'h000B, p, i[0]);
      chk(16'(cyc), 16'h0001, "compare latency");
      want = (i % 3 == 0) ? 16'h0009 : ((i % 3 == 1) ? 16'h0006 : 16'h0005);
      chk(16'(flags), want, "compare flags");
    end
  endtask
  task automatic t_host;
    @(posedge clk);
    #1;
    {host_flag_wr, host_user_flag_a, host_user_flag_b} = 3'h7;
    @(posedge clk);
    #1;
    host_flag_wr = 0;
    issue(16'h0006, 16'h0000, 1);
    chk(16'(irq_set), 16'h0000, "zero pattern irq");
    chk(16'(flags), 16'h0009, "flags kept");
  endtask
  task automatic t_false;
    bcsq_word_type ops [5] = '{16'h0004, 16'h0006, 16'h0007, 16'h0008, 16'h0009};
    foreach (ops[i])
    begin
      issue(ops[i], 16'h00FF, 0);
      chk(16'(cyc), 16'h0001, "false advance");
      chk(16'({return_valid, stopped, irq_set, flags}), 16'h0009, "false side effect");
    end
    issue(16'h0001, 16'h00FF, 1);
    chk(16'(cyc), 16'h0001, "foreign op advance");
    chk(16'({return_valid, stopped, irq_set, flags}), 16'h0009, "foreign op effect");
  endtask
  task automatic t_irq_stack;
    issue(16'h0006, 16'hFFF5, 1);
    chk(16'(irq_set), 16'h0005, "irq pattern");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      #1;
      push_valid = 1;
      push_addr = 16'h0010 + 16'(i);
    end
    @(posedge clk);
    #1;
    push_valid = 0;
    chk(16'(stack_depth), 16'h0004, "stack depth");
    issue(16'h0004, 16'hABCD, 1);
    chk(16'(return_valid), 16'h0001, "return valid");
    chk(return_addr, 16'h0013, "return pop");
    chk(16'(stack_depth), 16'h0003, "depth after pop");
  endtask
  task automatic t_stop_wait;
    issue(16'h0007, 16'h0000, 1);
    chk(16'({stopped, instr_ready}), 16'h0002, "stop");
    repeat (12) @(posedge clk);
    #1;
    chk(16'({stopped, instr_ready}), 16'h0001, "restart");
    issue(16'h0008, 16'h0002, 1);
    chk(16'(cyc >= 200 && cyc <= 205), 16'h0001, "delay length");
    frame_run = 1;
    issue(16'h0009, 16'h0000, 1);
    chk(frame_time, 16'h0000, "frame zero");
    chk(16'(cyc >= 60), 16'h0001, "frame stall");
  endtask
  initial
  begin
    #100000;
    n_errors++;
    results;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    chk(16'({instr_ready, instr_done, return_valid, irq_set, stopped}), 16'h0080, "reset ctl");
    chk(16'({stack_depth, flags}), 16'h0006, "reset stack flags");
    srst = 0;
    t_compare;
    t_host;
    t_false;
    t_irq_stack;
    t_stop_wait;
    results;
  end
endmodule
